// ==== hw/erxdm_pkg.sv ====
// erxdm_pkg: offsets, field positions, reset values and states of the
// receive descriptor manager.
// assumes a 32-bit classic wishbone slave port and 32-bit memory words.
package erxdm_pkg;

	// wishbone register byte offsets
	localparam logic [7:0]  ERXDM_CTRL_OFS  = 8'h00;
	localparam logic [7:0]  ERXDM_CFG_OFS   = 8'h04;
	localparam logic [7:0]  ERXDM_QBASE_OFS = 8'h08;
	localparam logic [7:0]  ERXDM_RSR_OFS   = 8'h0C;
	localparam logic [7:0]  ERXDM_RRE_OFS   = 8'h10;

	// control, configuration and status bit positions
	localparam int CTRL_RXEN_BIT   = 0;
	localparam int CFG_JUMBO_BIT   = 3;
	localparam int CFG_FCSDROP_BIT = 17;
	localparam int CFG_IGNFCS_BIT  = 26;
	localparam int RSR_BNA_BIT     = 0;

	// writable bits, reset values and the error count limit
	localparam logic [31:0] CTRL_MASK  = 32'h0000_0001;
	localparam logic [31:0] CFG_MASK   = 32'h0402_0008;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] CFG_RST    = 32'h0000_0000;
	localparam logic [31:0] QBASE_RST  = 32'h0000_0000;
	localparam logic [15:0] RRE_RST    = 16'h0000;
	localparam logic [15:0] RRE_MAX    = 16'hFFFF;

	// descriptor status word fields
	localparam int ST_VLAN_BIT  = 21;
	localparam int ST_PTAG_BIT  = 20;
	localparam int ST_PRIO_LSB  = 17;
	localparam int ST_CFI_BIT   = 16;
	localparam int ST_EOF_BIT   = 15;
	localparam int ST_SOF_BIT   = 14;
	localparam int ST_LEN13_BIT = 13;
	localparam int ST_LEN_W     = 13;
	localparam logic [15:0] VLAN_TPID = 16'h8100;

	// descriptor and buffer geometry
	localparam logic [31:0] DESC_STAT_OFS = 32'h0000_0004;
	localparam logic [31:0] DESC_BYTES    = 32'h0000_0008;
	localparam logic [13:0] FCS_BYTES     = 14'h0004;
	localparam int          BUF_BYTES     = 128;
	localparam int          BUF_WORDS     = BUF_BYTES / 4;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_DATA,
		ST_WRDATA,
		ST_WRSTAT,
		ST_WROWN,
		ST_DROP
	} erxdm_state_t;

endpackage

// ==== hw/erxdm_stat.sv ====
// erxdm_stat: builds the second descriptor word from frame information.
// assumes the frame fields are held stable by the caller while used.
`timescale 1ns/100ps
module erxdm_stat
	import erxdm_pkg::*;
(
	// mode bits
	input  wire logic        jumbo_i,
	input  wire logic        ignfcs_i,
	input  wire logic        fcsdrop_i,
	// frame information
	input  wire logic        sof_i,
	input  wire logic        eof_i,
	input  wire logic        fcs_bad_i,
	input  wire logic [13:0] len_i,
	input  wire logic [15:0] tpid_i,
	input  wire logic [15:0] tci_i,
	// status word
	output logic      [31:0] status_o
);

	logic [13:0] len_adj;
	logic        vlan;

	// fields are only filled on the last buffer; earlier ones carry sof alone
	always_comb
	begin
		len_adj = fcsdrop_i ? len_i - FCS_BYTES : len_i;
		vlan = (tpid_i == VLAN_TPID);
		status_o = 32'h0;
		status_o[ST_SOF_BIT] = sof_i;
		if (eof_i)
		begin
			status_o[ST_EOF_BIT] = 1'b1;
			status_o[ST_VLAN_BIT] = vlan;
			status_o[ST_PTAG_BIT] = vlan && (tci_i[11:0] == 12'h000);
			if (vlan)
			begin
				status_o[ST_PRIO_LSB +: 3] = tci_i[15:13];
				status_o[ST_CFI_BIT] = tci_i[12];
			end
			status_o[ST_LEN_W-1:0] = len_adj[ST_LEN_W-1:0];
			if (jumbo_i)
				status_o[ST_LEN13_BIT] = len_adj[13];
			else if (ignfcs_i)
				status_o[ST_LEN13_BIT] = fcs_bad_i;
		end
	end

endmodule

// ==== hw/erxdm_qptr.sv ====
// erxdm_qptr: queue base register and the internal descriptor pointer.
// assumes advance pulses come only after a descriptor was fully written.
`timescale 1ns/100ps
module erxdm_qptr
	import erxdm_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// software side
	input  wire logic        rx_en_i,
	input  wire logic        base_wr_i,
	input  wire logic [31:0] base_data_i,
	// engine side
	input  wire logic        adv_i,
	input  wire logic        wrap_i,
	output logic      [31:0] base_o,
	output logic      [31:0] ptr_o
);

	logic [31:0] base_q;
	logic [31:0] ptr_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// base load; word aligned since descriptors are word pairs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			base_q <= QBASE_RST;
		else if (base_wr_i && !rx_en_i)
			base_q <= {base_data_i[31:2], 2'b00};
	end

	// pointer follows a base write, otherwise steps or wraps
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ptr_q <= QBASE_RST;
		else if (base_wr_i && !rx_en_i)
			ptr_q <= {base_data_i[31:2], 2'b00};
		else if (adv_i && wrap_i)
			ptr_q <= base_q;
		else if (adv_i)
			ptr_q <= ptr_q + DESC_BYTES;
	end

	assign base_o = base_q;
	assign ptr_o  = ptr_q;

	base_locked_a: assert property (rx_en_i && base_wr_i |=> $stable(base_q))
		else $error("queue base changed while receive enabled");
	ptr_step_a: assert property (adv_i && !wrap_i && !base_wr_i |=> ptr_q == $past(ptr_q) + 32'h8)
		else $error("pointer did not step by two words");
	ptr_wrap_a: assert property (adv_i && wrap_i && !base_wr_i |=> ptr_q == $past(base_q))
		else $error("pointer did not reload base on wrap");

endmodule

// ==== hw/erxdm_top.sv ====
// erxdm_top: receive descriptor manager with a wishbone register slave.
// assumes mac receive words, filter verdict and memory port on clk_i.
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
module erxdm_top
	import erxdm_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// mac receive words
	input  wire logic        rx_valid_i,
	output logic             rx_ready_o,
	input  wire logic [31:0] rx_data_i,
	input  wire logic        rx_last_i,
	input  wire logic        rx_copy_i,
	input  wire logic        rx_err_i,
	input  wire logic        rx_fcs_bad_i,
	input  wire logic [13:0] rx_len_i,
	input  wire logic [15:0] rx_tpid_i,
	input  wire logic [15:0] rx_tci_i,
	// system memory port
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic      [31:0] mem_addr_o,
	output logic      [31:0] mem_wdata_o,
	input  wire logic [31:0] mem_rdata_i,
	input  wire logic        mem_ack_i,
	// no-buffer event
	output logic             bna_evt_o
);

	erxdm_state_t state_q;
	logic        mem_req_q;
	logic        mem_we_q;
	logic [31:0] mem_addr_q;
	logic [31:0] mem_wdata_q;
	logic [29:0] buf_q;
	logic        wrap_q;
	logic [5:0]  off_q;
	logic        sof_q;
	logic        last_q;
	logic        err_q;
	logic        fcs_bad_q;
	logic [13:0] len_q;
	logic [15:0] tpid_q;
	logic [15:0] tci_q;
	logic [31:0] ctrl_q;
	logic [31:0] cfg_q;
	logic        bna_q;
	logic [15:0] rre_q;
	logic        wb_ack_q;
	logic [31:0] wb_dat_q;
	logic        wb_hit;
	logic        wr_fire;
	logic        rx_en;
	logic        buf_full;
	logic        bna_hit;
	logic        adv;
	logic [31:0] qbase;
	logic [31:0] qptr;
	logic [31:0] stat_word;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// byte-lane merge of a register write
	function automatic logic [31:0] erxdm_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				res[8*i +: 8] = new_v[8*i +: 8];
		return res;
	endfunction

	assign rx_en    = ctrl_q[CTRL_RXEN_BIT];
	assign buf_full = (off_q == 6'(BUF_WORDS));
	assign bna_hit  = (state_q == ST_FETCH) && mem_req_q && mem_ack_i && mem_rdata_i[0];
	assign adv      = (state_q == ST_WROWN) && mem_ack_i;

	erxdm_qptr u_qptr (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.rx_en_i     (rx_en),
		.base_wr_i   (wr_fire && (wb_adr_i == ERXDM_QBASE_OFS)),
		.base_data_i (erxdm_merge(qbase, wb_dat_i, wb_sel_i)),
		.adv_i       (adv),
		.wrap_i      (wrap_q),
		.base_o      (qbase),
		.ptr_o       (qptr)
	);

	erxdm_stat u_stat (
		.jumbo_i   (cfg_q[CFG_JUMBO_BIT]),
		.ignfcs_i  (cfg_q[CFG_IGNFCS_BIT]),
		.fcsdrop_i (cfg_q[CFG_FCSDROP_BIT]),
		.sof_i     (sof_q),
		.eof_i     (last_q),
		.fcs_bad_i (fcs_bad_q),
		.len_i     (len_q),
		.tpid_i    (tpid_q),
		.tci_i     (tci_q),
		.status_o  (stat_word)
	);

	// mac side is ready only when a word can be parked or discarded
	assign rx_ready_o = (state_q == ST_DROP) || ((state_q == ST_DATA) && !buf_full);

	// descriptor walk and memory requests; req stays up across chained writes
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q     <= ST_IDLE;
			mem_req_q   <= 1'b0;
			mem_we_q    <= 1'b0;
			mem_addr_q  <= 32'h0;
			mem_wdata_q <= 32'h0;
			buf_q       <= 30'h0;
			wrap_q      <= 1'b0;
			off_q       <= 6'h0;
			sof_q       <= 1'b0;
			last_q      <= 1'b0;
			err_q       <= 1'b0;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
					if (rx_valid_i && rx_en)
					begin
						if (rx_copy_i)
						begin
							state_q <= ST_FETCH;
							sof_q   <= 1'b1;
						end
						else
							state_q <= ST_DROP;
					end
				ST_FETCH:
					if (!mem_req_q)
					begin
						mem_req_q  <= 1'b1;
						mem_we_q   <= 1'b0;
						mem_addr_q <= qptr;
					end
					else if (mem_ack_i)
					begin
						mem_req_q <= 1'b0;
						last_q    <= 1'b0;
						if (mem_rdata_i[0])
							state_q <= ST_DROP;
						else
						begin
							buf_q   <= mem_rdata_i[31:2];
							wrap_q  <= mem_rdata_i[1];
							off_q   <= 6'h0;
							state_q <= ST_DATA;
						end
					end
				ST_DATA:
					// full buffer closes without end of frame
					if (buf_full)
					begin
						mem_req_q   <= 1'b1;
						mem_we_q    <= 1'b1;
						mem_addr_q  <= qptr + DESC_STAT_OFS;
						mem_wdata_q <= stat_word;
						state_q     <= ST_WRSTAT;
					end
					else if (rx_valid_i)
					begin
						mem_req_q   <= 1'b1;
						mem_we_q    <= 1'b1;
						mem_addr_q  <= {buf_q, 2'b00} + {24'h0, off_q, 2'b00};
						mem_wdata_q <= rx_data_i;
						last_q      <= rx_last_i;
						err_q       <= rx_err_i;
						state_q     <= ST_WRDATA;
					end
				ST_WRDATA:
					if (mem_ack_i)
					begin
						off_q <= off_q + 6'h1;
						if (!last_q)
						begin
							mem_req_q <= 1'b0;
							state_q   <= ST_DATA;
						end
						// error leaves buffer unowned for reuse
						else if (err_q)
						begin
							mem_req_q <= 1'b0;
							sof_q     <= 1'b0;
							state_q   <= ST_IDLE;
						end
						else
						begin
							mem_addr_q  <= qptr + DESC_STAT_OFS;
							mem_wdata_q <= stat_word;
							state_q     <= ST_WRSTAT;
						end
					end
				ST_WRSTAT:
					if (mem_ack_i)
					begin
						mem_addr_q  <= qptr;
						mem_wdata_q <= {buf_q, wrap_q, 1'b1};
						state_q     <= ST_WROWN;
					end
				ST_WROWN:
					if (mem_ack_i)
					begin
						mem_req_q <= 1'b0;
						sof_q     <= 1'b0;
						state_q   <= last_q ? ST_IDLE : ST_FETCH;
					end
				ST_DROP:
					if (rx_valid_i && rx_last_i)
						state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// frame trailer fields, captured with the last word
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fcs_bad_q <= 1'b0;
			len_q     <= 14'h0;
			tpid_q    <= 16'h0;
			tci_q     <= 16'h0;
		end
		else if ((state_q == ST_DATA) && !buf_full && rx_valid_i && rx_last_i)
		begin
			fcs_bad_q <= rx_fcs_bad_i;
			len_q     <= rx_len_i;
			tpid_q    <= rx_tpid_i;
			tci_q     <= rx_tci_i;
		end
	end

	assign mem_req_o   = mem_req_q;
	assign mem_we_o    = mem_we_q;
	assign mem_addr_o  = mem_addr_q;
	assign mem_wdata_o = mem_wdata_q;

	// wishbone ack one cycle after the strobe, dropped the next cycle
	assign wb_hit  = wb_cyc_i && wb_stb_i && !wb_ack_q;
	assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_q;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_q <= 1'b0;
			wb_dat_q <= 32'h0;
		end
		else
		begin
			wb_ack_q <= wb_hit;
			if (wb_hit)
			begin
				case (wb_adr_i)
					ERXDM_CTRL_OFS:  wb_dat_q <= ctrl_q;
					ERXDM_CFG_OFS:   wb_dat_q <= cfg_q;
					ERXDM_QBASE_OFS: wb_dat_q <= qptr;
					ERXDM_RSR_OFS:   wb_dat_q <= {31'h0, bna_q};
					ERXDM_RRE_OFS:   wb_dat_q <= {16'h0, rre_q};
					default:         wb_dat_q <= 32'h0;
				endcase
			end
		end
	end

	assign wb_ack_o = wb_ack_q;
	assign wb_dat_o = wb_dat_q;

	// control and configuration; writes land on the acking edge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q <= CTRL_RST;
			cfg_q  <= CFG_RST;
		end
		else if (wr_fire && (wb_adr_i == ERXDM_CTRL_OFS))
			ctrl_q <= erxdm_merge(ctrl_q, wb_dat_i, wb_sel_i) & CTRL_MASK;
		else if (wr_fire && (wb_adr_i == ERXDM_CFG_OFS))
			cfg_q <= erxdm_merge(cfg_q, wb_dat_i, wb_sel_i) & CFG_MASK;
	end

	// no-buffer flag and error count; a new event beats a clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bna_q <= 1'b0;
			rre_q <= RRE_RST;
		end
		else
		begin
			if (bna_hit)
				bna_q <= 1'b1;
			else if (wr_fire && (wb_adr_i == ERXDM_RSR_OFS) && wb_sel_i[0]
				&& wb_dat_i[RSR_BNA_BIT])
				bna_q <= 1'b0;
			// saturating count so software never sees a wrap
			if (bna_hit && (rre_q != RRE_MAX))
				rre_q <= rre_q + 16'h1;
		end
	end

	assign bna_evt_o = bna_hit;

	sequence stat_done_s;
		state_q == ST_WRSTAT && mem_ack_i;
	endsequence
	sequence own_write_s;
		state_q == ST_WROWN && mem_req_q && mem_we_q && mem_wdata_q[0];
	endsequence

	stat_then_own_a: assert property (stat_done_s |=> own_write_s)
		else $error("owner write did not follow status write");
	own_from_stat_a: assert property ($rose(state_q == ST_WROWN) |-> $past(state_q) == ST_WRSTAT)
		else $error("owner write without prior status write");
	bna_count_a: assert property (bna_hit && rre_q != RRE_MAX |=> bna_q && rre_q == $past(rre_q) + 16'h1)
		else $error("no-buffer event not flagged and counted");
	bna_skip_a: assert property (bna_hit |=> state_q == ST_DROP && !mem_req_q)
		else $error("owned buffer was used");
	eof_bit_a: assert property (state_q == ST_WRSTAT |-> mem_wdata_q[ST_EOF_BIT] == last_q)
		else $error("end of frame bit wrong");
	bit13_zero_a: assert property (state_q == ST_WRSTAT && !cfg_q[CFG_JUMBO_BIT] && !cfg_q[CFG_IGNFCS_BIT] |-> !mem_wdata_q[ST_LEN13_BIT])
		else $error("bit 13 set with both modes off");
	vlan_bit_a: assert property (state_q == ST_WRSTAT && last_q |-> mem_wdata_q[ST_VLAN_BIT] == (tpid_q == VLAN_TPID))
		else $error("vlan detected bit wrong");
	copy_gate_a: assert property (state_q == ST_IDLE && rx_valid_i && rx_en && !rx_copy_i |=> state_q == ST_DROP)
		else $error("uncopied frame was stored");
	buf_limit_a: assert property (off_q <= 6'h20)
		else $error("buffer overran 128 bytes");

endmodule

// ==== verification/erxdm_mem_model.sv ====
// erxdm_mem_model: word memory answering the engine's memory port.
// assumes byte addresses below 1 KB; the bench preloads descriptors directly.
`timescale 1ns/100ps
module erxdm_mem_model
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// memory port
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [31:0] wdata_i,
	output logic      [31:0] rdata_o,
	output logic             ack_o,
	// answer speed
	input  wire logic        slow_i
);
	logic [31:0] mem [0:255];
	logic [31:0] rd_q;
	logic [1:0]  wait_q;

	// read data only holds with ack; otherwise the inverse, never a stale copy
	assign rdata_o = ack_o ? rd_q : ~rd_q;

	// one ack per request; slow mode waits three cycles more
	always @(posedge clk_i)
	begin
		if (rst_i || !req_i || ack_o)
		begin
			ack_o  <= 1'h0;
			wait_q <= 2'h0;
		end
		else if (!slow_i || wait_q == 2'h3)
		begin
			ack_o <= 1'h1;
			rd_q  <= mem[addr_i[9:2]];
			if (we_i)
				mem[addr_i[9:2]] <= wdata_i;
		end
		else
			wait_q <= wait_q + 2'h1;
	end
endmodule

// ==== verification/eth_rx_descriptor_manager_bench.sv ====
// eth_rx_descriptor_manager_bench: self-checking bench of the descriptor manager.
// assumes the memory model beside it and a three-entry ring at 100h.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module eth_rx_descriptor_manager_bench
	import erxdm_pkg::*;
;
	logic        clk, rst, wb_cyc, wb_stb, wb_we, rx_valid, rx_last, rx_copy;
	logic        rx_err, rx_bad, mem_slow, wb_ack_o, rx_ready_o, mem_req, mem_we;
	logic        mem_ack, bna_evt_o;
	logic [7:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [13:0] rx_len;
	logic [15:0] rx_tpid, rx_tci;
	logic [31:0] wb_dat, rx_data, wb_dat_o, mem_addr, mem_wdata, mem_rdata, rd;
	int          fails, n_compared, bna_cnt, cycles, idx;
	typedef struct {
		logic [31:0] cfg;
		logic [13:0] len;
		logic        bad;
		logic [15:0] tpid;
		logic [15:0] tci;
		logic [31:0] exp;
	} erxdm_row_t;
	// mode bits, trailer fields and the status word they should give
	erxdm_row_t rows [10] = '{
		'{32'h0000_0000, 14'h0040, 1'h0, 16'h0800, 16'h0000, 32'h0000_C040},
		'{32'h0002_0000, 14'h0040, 1'h0, 16'h0800, 16'h0000, 32'h0000_C03C},
		'{32'h0400_0000, 14'h0040, 1'h1, 16'h0800, 16'h0000, 32'h0000_E040},
		'{32'h0400_0000, 14'h0040, 1'h0, 16'h0800, 16'h0000, 32'h0000_C040},
		'{32'h0000_0008, 14'h2345, 1'h0, 16'h0800, 16'h0000, 32'h0000_E345},
		'{32'h0000_0000, 14'h0040, 1'h1, 16'h0800, 16'h0000, 32'h0000_C040},
		'{32'h0000_0000, 14'h0040, 1'h0, 16'h8100, 16'hB123, 32'h002B_C040},
		'{32'h0000_0000, 14'h0040, 1'h0, 16'h8100, 16'h6000, 32'h0036_C040},
		'{32'h0000_0000, 14'h0040, 1'h0, 16'h88A8, 16'hB123, 32'h0000_C040},
		'{32'h0402_0008, 14'h2004, 1'h1, 16'h0800, 16'h0000, 32'h0000_E000}
	};

	erxdm_top i_erxdm_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid),
		.rx_ready_o(rx_ready_o), .rx_data_i(rx_data), .rx_last_i(rx_last),
		.rx_copy_i(rx_copy), .rx_err_i(rx_err), .rx_fcs_bad_i(rx_bad), .rx_len_i(rx_len),
		.rx_tpid_i(rx_tpid), .rx_tci_i(rx_tci), .mem_req_o(mem_req), .mem_we_o(mem_we),
		.mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata),
		.mem_ack_i(mem_ack), .bna_evt_o(bna_evt_o));
	erxdm_mem_model i_erxdm_mem_model (.clk_i(clk), .rst_i(rst), .req_i(mem_req),
		.we_i(mem_we), .addr_i(mem_addr), .wdata_i(mem_wdata), .rdata_o(mem_rdata),
		.ack_o(mem_ack), .slow_i(mem_slow));

	// clock, event counter and hang guard
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (bna_evt_o === 1'h1)
			bna_cnt <= bna_cnt + 1;
		if (cycles == 30000)
		begin
			fails++;
			test_done;
		end
	end

	// ring geometry: descriptor, buffer and first word of entry k
	function automatic logic [31:0] dsc(input int k);
		return 32'h0000_0100 + 32'(8 * (k % 3));
	endfunction
	function automatic logic [31:0] bfa(input int k);
		return 32'h0000_0200 + 32'(128 * (k % 3));
	endfunction
	function automatic logic [31:0] w0(input int k);
		return bfa(k) | ((k % 3 == 2) ? 32'h0000_0002 : 32'h0000_0000);
	endfunction

	// one classic wishbone cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		begin
			wb_cyc <= 1'h1;
			wb_stb <= 1'h1;
			wb_we  <= we;
			wb_adr <= adr;
			wb_dat <= wd;
			wb_sel <= 4'hF;
			// no own limit: only the bench's hang guard ends this wait
			do
				@(posedge clk);
			while (wb_ack_o !== 1'h1);
			rd = wb_dat_o;
			wb_cyc <= 1'h0;
			wb_stb <= 1'h0;
			@(posedge clk);
		end
	endtask
	task automatic chk_reg(input logic [7:0] adr, input logic [31:0] e, input string nm);
		wb(1'h0, adr, 32'h0000_0000);
		`CHK(nm, e, rd)
	endtask
	task automatic chk_mem(input logic [31:0] a, input logic [31:0] e, input string nm);
		`CHK(nm, e, i_erxdm_mem_model.mem[a[9:2]])
	endtask

	// one frame of n words, each held until the engine takes it
	task automatic send(input logic cp, input int n, input logic [13:0] len, input logic bad,
		input logic err, input logic [15:0] tpid, input logic [15:0] tci);
		logic ok;
		int   t;
		begin
			rx_err  <= err;
			rx_bad  <= bad;
			rx_len  <= len;
			rx_tpid <= tpid;
			rx_tci  <= tci;
			rx_copy <= cp;
			for (int i = 0; i < n; i++)
			begin
				rx_valid <= 1'h1;
				rx_data  <= 32'hD000_0000 + 32'(i);
				rx_last  <= (i == n - 1);
				t = 0;
				do
				begin
					@(negedge clk);
					ok = rx_ready_o;
					@(posedge clk);
					t++;
				end
				while (ok !== 1'h1 && t < 300);
				if (t >= 300)
					fails++;
			end
			rx_valid <= 1'h0;
			rx_last  <= 1'h0;
		end
	endtask
	// wait, bounded, for the owner bit of a descriptor
	task automatic settle(input logic [31:0] d);
		for (int t = 0; t < 300 && i_erxdm_mem_model.mem[d[9:2]][0] !== 1'h1; t++)
			@(posedge clk);
		repeat (4) @(posedge clk);
	endtask

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		{clk, wb_cyc, wb_stb, wb_we, rx_valid, rx_last, rx_copy, rx_err, rx_bad} = '0;
		{wb_adr, wb_sel, wb_dat, rx_data, rx_len, rx_tpid, rx_tci, mem_slow} = '0;
		{fails, n_compared, bna_cnt, cycles, idx} = '0;
		rst = 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		chk_reg(ERXDM_CTRL_OFS, CTRL_RST, "ctrl");
		chk_reg(ERXDM_CFG_OFS, CFG_RST, "cfg");
		chk_reg(ERXDM_RRE_OFS, 32'h0000_0000, "rre");
		chk_reg(8'h14, 32'h0000_0000, "unmapped");
		for (int k = 0; k < 3; k++)
			i_erxdm_mem_model.mem[dsc(k) >> 2] = w0(k);
		wb(1'h1, ERXDM_QBASE_OFS, 32'h0000_0100);
		chk_reg(ERXDM_QBASE_OFS, 32'h0000_0100, "qbase");
		wb(1'h1, ERXDM_CTRL_OFS, 32'h0000_0001);
		wb(1'h1, ERXDM_QBASE_OFS, 32'h0000_0180);
		for (int r = 0; r < 10; r++)
		begin
			mem_slow <= r[0];
			wb(1'h1, ERXDM_CFG_OFS, rows[r].cfg);
			i_erxdm_mem_model.mem[dsc(idx) >> 2] = w0(idx);
			send(1'h1, 2, rows[r].len, rows[r].bad, 1'h0, rows[r].tpid, rows[r].tci);
			settle(dsc(idx));
			chk_mem(dsc(idx) + 4, rows[r].exp, "status");
			chk_mem(dsc(idx), w0(idx) | 1, "owner");
			chk_mem(bfa(idx) + 4, 32'hD000_0001, "data");
			idx++;
		end
		// errored frame and a frame the filter rejects leave the entry free
		wb(1'h1, ERXDM_CFG_OFS, 32'h0000_0000);
		// entry still owned from the row loop; hand it back first
		i_erxdm_mem_model.mem[dsc(idx) >> 2] = w0(idx);
		send(1'h1, 2, 14'h0040, 1'h0, 1'h1, 16'h0800, 16'h0000);
		settle(dsc(idx));
		chk_mem(dsc(idx), w0(idx), "error owner");
		send(1'h0, 2, 14'h0040, 1'h0, 1'h0, 16'h0800, 16'h0000);
		settle(dsc(idx));
		chk_mem(dsc(idx), w0(idx), "drop owner");
		// frame across two buffers; scan owner, start and end as software would
		i_erxdm_mem_model.mem[dsc(idx + 1) >> 2] = w0(idx + 1);
		send(1'h1, 33, 14'h0084, 1'h0, 1'h0, 16'h0800, 16'h0000);
		settle(dsc(idx + 1));
		chk_mem(dsc(idx) + 4, 32'h0000_4000, "first status");
		chk_mem(dsc(idx + 1) + 4, 32'h0000_8084, "last status");
		chk_mem(bfa(idx) + 124, 32'hD000_001F, "buffer end");
		chk_mem(bfa(idx + 1), 32'hD000_0020, "next buffer");
		chk_mem(dsc(idx), w0(idx) | 1, "first owner");
		idx += 2;
		wb(1'h1, ERXDM_CTRL_OFS, 32'h0000_0000);
		chk_reg(ERXDM_QBASE_OFS, dsc(idx), "pointer");
		// owned descriptor: no buffer event
		wb(1'h1, ERXDM_CTRL_OFS, 32'h0000_0001);
		i_erxdm_mem_model.mem[dsc(idx) >> 2] = w0(idx) | 1;
		send(1'h1, 2, 14'h0040, 1'h0, 1'h0, 16'h0800, 16'h0000);
		repeat (8) @(posedge clk);
		`CHK("bna pulses", 1, bna_cnt)
		chk_mem(dsc(idx) + 4, rows[9].exp, "skipped status");
		chk_reg(ERXDM_RSR_OFS, 32'h0000_0001, "rsr");
		wb(1'h1, ERXDM_RRE_OFS, 32'h0000_0000);
		chk_reg(ERXDM_RRE_OFS, 32'h0000_0001, "rre");
		wb(1'h1, ERXDM_RSR_OFS, 32'h0000_0001);
		chk_reg(ERXDM_RSR_OFS, 32'h0000_0000, "rsr clear");
		// mid-run reset brings pointer and error count back to reset values
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		chk_reg(ERXDM_QBASE_OFS, QBASE_RST, "qbase after reset");
		chk_reg(ERXDM_RRE_OFS, 32'h0000_0000, "rre after reset");
		test_done;
	end
endmodule
